// ==== pci_route_pkg.sv ====
/*
  constants and types for the pci bar resource decoder.
  assumes a single pci clock domain; no other files needed.
*/
`default_nettype none

package pci_route_pkg;

  // ==========================================================
  // bar indices
  typedef logic [2:0] bar_t;
  localparam bar_t BAR0 = 3'h0;
  localparam bar_t BAR1 = 3'h1;
  localparam bar_t BAR2 = 3'h2;
  localparam bar_t BAR3 = 3'h3;
  localparam bar_t BAR4 = 3'h4;
  localparam bar_t BAR5 = 3'h5;

  // ==========================================================
  // operating mode codes
  typedef logic [2:0] mode_t;
  localparam mode_t MODE_000 = 3'h0;
  localparam mode_t MODE_001 = 3'h1;
  localparam mode_t MODE_010 = 3'h2;
  localparam mode_t MODE_011 = 3'h3;
  localparam mode_t MODE_100 = 3'h4;
  localparam mode_t MODE_101 = 3'h5;

  // ==========================================================
  // resource targets
  typedef enum logic [2:0] {
    TGT_NONE    = 3'b000,
    TGT_UART    = 3'b001,
    TGT_LCR     = 3'b010,
    TGT_LBUS    = 3'b011,
    TGT_PP_BASE = 3'b100,
    TGT_PP_EXT  = 3'b101
  } target_e;

  // ==========================================================
  // offset fields
  localparam int OFS_W       = 12;
  localparam int RES_OFS_W   = 8;
  localparam int UREG_W      = 3;
  localparam int CHAN_W      = 2;
  localparam int IO_CH_LSB   = 3;
  localparam int MEM_CH_LSB  = 5;
  localparam int MEM_REG_LSB = 2;
  localparam int MEM_SEL_BIT = 7;
  typedef logic [CHAN_W-1:0] chan_t;

endpackage

`default_nettype wire

// ==== route_if.sv ====
/*
  carrier between the top decoder and the function-1 decoder.
  assumes both ends sit in the same clock domain.
*/
`default_nettype none

interface route_if;
  pci_route_pkg::bar_t                          bar;
  logic                                         is_io;
  logic [pci_route_pkg::RES_OFS_W-1:0]          offset;
  pci_route_pkg::mode_t                         mode;
  logic                                         hit;
  pci_route_pkg::target_e                       target;
  logic [pci_route_pkg::RES_OFS_W-1:0]          res_offset;

  modport requester (output bar, output is_io, output offset, output mode,
                     input hit, input target, input res_offset);
  modport decoder   (input bar, input is_io, input offset, input mode,
                     output hit, output target, output res_offset);
endinterface

`default_nettype wire

// ==== f1_route_decode.sv ====
/*
  combinational bar decode for function 1 (local bus or parallel port).
  assumes the caller registers the result.
*/
`default_nettype none

module f1_route_decode (
  route_if.decoder rt
);

  logic lbus;
  logic ppt;

  // ==========================================================
  // mode classes
  assign lbus = (rt.mode == pci_route_pkg::MODE_000) ||
                (rt.mode == pci_route_pkg::MODE_011) ||
                (rt.mode == pci_route_pkg::MODE_100); // RULE9
  assign ppt  = (rt.mode == pci_route_pkg::MODE_001) ||
                (rt.mode == pci_route_pkg::MODE_101);

  // ==========================================================
  // bar to resource
  always_comb begin
    rt.target = pci_route_pkg::TGT_NONE;
    unique case (rt.bar)
      pci_route_pkg::BAR0: begin
        if (lbus && rt.is_io) rt.target = pci_route_pkg::TGT_LBUS; // RULE7
        else if (ppt && rt.is_io) rt.target = pci_route_pkg::TGT_PP_BASE; // RULE8
      end
      pci_route_pkg::BAR1: begin
        if (lbus && !rt.is_io) rt.target = pci_route_pkg::TGT_LBUS; // RULE7
        else if (ppt && rt.is_io) rt.target = pci_route_pkg::TGT_PP_EXT; // RULE8
      end
      pci_route_pkg::BAR2: begin
        if ((lbus || ppt) && rt.is_io) rt.target = pci_route_pkg::TGT_LCR; // RULE7
      end
      pci_route_pkg::BAR3: begin
        if ((lbus || ppt) && !rt.is_io) rt.target = pci_route_pkg::TGT_LCR; // RULE7
      end
      default: rt.target = pci_route_pkg::TGT_NONE; // RULE12
    endcase
  end

  assign rt.hit        = (rt.target != pci_route_pkg::TGT_NONE);
  assign rt.res_offset = rt.offset;

endmodule

`default_nettype wire

// ==== pci_bar_resource_decoder.sv ====
/*
  steers pci target accesses that hit a bar window to an internal resource.
  assumes bar hit, space type and offset come from the pci target core,
  synchronous to clock_i, and that mode inputs are stable during use.
*/
`default_nettype none

// Overview of operation
// [RULE1] shared mode, function 0: bar 0 i/o and bar 1 memory reach the four serial channels.
// [RULE2] shared mode, function 0: bar 2 i/o and bar 3 memory reach the local config registers.
// [RULE3] per-channel mode, function 0: bars 0 to 3 are i/o windows of channels 0 to 3.
// [RULE4] per-channel mode, function 0: bar 4 is the i/o window of the local config registers.
// [RULE5] per-channel mode, function 0: bar 5 is one memory window for channels and registers.
// [RULE6] in the bar 5 window, offset bit 7 low picks channels and high picks registers.
// [RULE7] function 1 local bus: bar 0 i/o and bar 1 memory reach the bus; bars 2, 3 registers.
// [RULE8] function 1 parallel port: bar 0 is the base and bar 1 the extended port block.
// [RULE9] function 1 acts as the local bus in modes 000, 011 and 100.
// [RULE10] software assigns every implemented bar a correctly sized block before use.
// [RULE11] the mode picks the bar-to-resource map, so one bar index can reach different things.
// [RULE12] accesses to a bar unused in the active mode are not claimed.

module pci_bar_resource_decoder (
  input  wire logic                                clock_i,
  input  wire logic                                reset_i,
  input  wire logic                                ce_i,
  input  wire logic                                req_valid_i,
  input  wire logic                                req_func_i,
  input  wire logic [2:0]                          req_bar_i,
  input  wire logic                                req_io_i,
  input  wire logic [pci_route_pkg::OFS_W-1:0]     req_offset_i,
  input  wire logic [2:0]                          f0_mode_i,
  input  wire logic                                f0_unique_opt_i,
  input  wire logic [2:0]                          f1_mode_i,
  output logic                                     claim_o,
  output logic                                     miss_o,
  output pci_route_pkg::target_e                   target_o,
  output logic [pci_route_pkg::CHAN_W-1:0]         channel_o,
  output logic [pci_route_pkg::RES_OFS_W-1:0]      res_offset_o
);

  localparam int PAD_W = pci_route_pkg::RES_OFS_W - pci_route_pkg::UREG_W;

  logic                                 unique_bar;
  pci_route_pkg::target_e               f0_target;
  pci_route_pkg::chan_t                 f0_chan;
  logic [pci_route_pkg::RES_OFS_W-1:0]  f0_ofs;
  logic [pci_route_pkg::UREG_W-1:0]     io_reg;
  logic [pci_route_pkg::UREG_W-1:0]     mem_reg;
  pci_route_pkg::chan_t                 io_chan;
  pci_route_pkg::chan_t                 mem_chan;
  logic [pci_route_pkg::RES_OFS_W-1:0]  low_ofs;
  logic                                 take;
  logic                                 hit;

  logic                                 claim_q;
  logic                                 miss_q;
  pci_route_pkg::target_e               target_q;
  pci_route_pkg::chan_t                 channel_q;
  logic [pci_route_pkg::RES_OFS_W-1:0]  res_offset_q;

  route_if rt ();

  // ==========================================================
  // offset fields
  assign io_reg   = req_offset_i[pci_route_pkg::UREG_W-1:0];
  assign mem_reg  = req_offset_i[pci_route_pkg::MEM_REG_LSB +: pci_route_pkg::UREG_W];
  assign io_chan  = req_offset_i[pci_route_pkg::IO_CH_LSB +: pci_route_pkg::CHAN_W];
  assign mem_chan = req_offset_i[pci_route_pkg::MEM_CH_LSB +: pci_route_pkg::CHAN_W];
  assign low_ofs  = req_offset_i[pci_route_pkg::RES_OFS_W-1:0];
  assign take     = req_valid_i && ce_i;

  // ==========================================================
  // function 0 map selection
  assign unique_bar = (f0_mode_i == pci_route_pkg::MODE_011) ||
                      (((f0_mode_i == pci_route_pkg::MODE_100) ||
                        (f0_mode_i == pci_route_pkg::MODE_101)) && f0_unique_opt_i); // RULE11

  // ==========================================================
  // function 0 decode
  always_comb begin
    f0_target = pci_route_pkg::TGT_NONE;
    f0_chan   = '0;
    f0_ofs    = low_ofs;
    if (!unique_bar) begin
      unique case (req_bar_i)
        pci_route_pkg::BAR0: begin
          if (req_io_i) begin
            f0_target = pci_route_pkg::TGT_UART; // RULE1
            f0_chan   = io_chan;
            f0_ofs    = {{PAD_W{1'b0}}, io_reg};
          end
        end
        pci_route_pkg::BAR1: begin
          if (!req_io_i) begin
            f0_target = pci_route_pkg::TGT_UART; // RULE1
            f0_chan   = mem_chan;
            f0_ofs    = {{PAD_W{1'b0}}, mem_reg};
          end
        end
        pci_route_pkg::BAR2: begin
          if (req_io_i) f0_target = pci_route_pkg::TGT_LCR; // RULE2
        end
        pci_route_pkg::BAR3: begin
          if (!req_io_i) f0_target = pci_route_pkg::TGT_LCR; // RULE2
        end
        default: f0_target = pci_route_pkg::TGT_NONE; // RULE12
      endcase
    end else begin
      unique case (req_bar_i)
        pci_route_pkg::BAR0,
        pci_route_pkg::BAR1,
        pci_route_pkg::BAR2,
        pci_route_pkg::BAR3: begin
          if (req_io_i) begin
            f0_target = pci_route_pkg::TGT_UART; // RULE3
            f0_chan   = req_bar_i[pci_route_pkg::CHAN_W-1:0];
            f0_ofs    = {{PAD_W{1'b0}}, io_reg};
          end
        end
        pci_route_pkg::BAR4: begin
          if (req_io_i) f0_target = pci_route_pkg::TGT_LCR; // RULE4
        end
        pci_route_pkg::BAR5: begin
          if (!req_io_i) begin
            if (req_offset_i[pci_route_pkg::MEM_SEL_BIT]) begin
              f0_target = pci_route_pkg::TGT_LCR; // RULE6
            end else begin
              f0_target = pci_route_pkg::TGT_UART; // RULE5
              f0_chan   = mem_chan;
              f0_ofs    = {{PAD_W{1'b0}}, mem_reg};
            end
          end
        end
        default: f0_target = pci_route_pkg::TGT_NONE; // RULE12
      endcase
    end
  end

  // ==========================================================
  // function 1 decode
  assign rt.bar    = req_bar_i;
  assign rt.is_io  = req_io_i;
  assign rt.offset = low_ofs;
  assign rt.mode   = f1_mode_i;

  f1_route_decode u_f1 (
    .rt (rt)
  );

  assign hit = req_func_i ? rt.hit : (f0_target != pci_route_pkg::TGT_NONE); // RULE12

  // ==========================================================
  // handshake outputs
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      claim_q <= 1'b0;
      miss_q  <= 1'b0;
    end else if (ce_i) begin
      claim_q <= req_valid_i && hit;
      miss_q  <= req_valid_i && !hit; // RULE12
    end
  end

  // ==========================================================
  // routing data
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      target_q     <= pci_route_pkg::TGT_NONE;
      channel_q    <= '0;
      res_offset_q <= '0;
    end else if (take) begin
      if (req_func_i) begin
        target_q     <= rt.target;
        channel_q    <= '0;
        res_offset_q <= rt.res_offset;
      end else begin
        target_q     <= f0_target;
        channel_q    <= f0_chan;
        res_offset_q <= f0_ofs;
      end
    end
  end

  assign claim_o      = claim_q;
  assign miss_o       = miss_q;
  assign target_o     = target_q;
  assign channel_o    = channel_q;
  assign res_offset_o = res_offset_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_shared_io_uart: assert property (take && !req_func_i && !unique_bar && // RULE1
      req_bar_i == pci_route_pkg::BAR0 && req_io_i |=> claim_o &&
      target_o == pci_route_pkg::TGT_UART && channel_o == $past(io_chan))
    else $error("shared bar 0 i/o not sent to channel");
  a_shared_mem_uart: assert property (take && !req_func_i && !unique_bar && // RULE1
      req_bar_i == pci_route_pkg::BAR1 && !req_io_i |=> claim_o &&
      channel_o == $past(mem_chan) && res_offset_o == {{PAD_W{1'b0}}, $past(mem_reg)})
    else $error("shared bar 1 memory not sent to channel");
  a_shared_lcr_map: assert property (take && !req_func_i && !unique_bar && // RULE2
      ((req_bar_i == pci_route_pkg::BAR2 && req_io_i) ||
       (req_bar_i == pci_route_pkg::BAR3 && !req_io_i)) |=>
      claim_o && target_o == pci_route_pkg::TGT_LCR)
    else $error("shared config window misrouted");
  a_unused_bar_miss: assert property (take && !req_func_i && !unique_bar && // RULE12
      req_bar_i >= pci_route_pkg::BAR4 |=> !claim_o && miss_o)
    else $error("unused bar claimed");
  a_unique_chan_bar: assert property (take && !req_func_i && unique_bar && // RULE3
      req_io_i && req_bar_i < pci_route_pkg::BAR4 |=> claim_o &&
      channel_o == $past(req_bar_i[pci_route_pkg::CHAN_W-1:0]))
    else $error("per-channel window wrong channel");
  a_unique_lcr_io: assert property (take && !req_func_i && unique_bar && // RULE4
      req_io_i && req_bar_i == pci_route_pkg::BAR4 |=>
      target_o == pci_route_pkg::TGT_LCR)
    else $error("bar 4 not config registers");
  a_bar5_selector: assert property (take && !req_func_i && unique_bar && // RULE6
      !req_io_i && req_bar_i == pci_route_pkg::BAR5 |=> claim_o && target_o ==
      ($past(req_offset_i[pci_route_pkg::MEM_SEL_BIT]) ?
       pci_route_pkg::TGT_LCR : pci_route_pkg::TGT_UART))
    else $error("bar 5 selector wrong");
  a_f1_lbus_route: assert property (take && req_func_i && // RULE9
      f1_mode_i == pci_route_pkg::MODE_011 && req_bar_i == pci_route_pkg::BAR1 &&
      !req_io_i |=> claim_o && target_o == pci_route_pkg::TGT_LBUS)
    else $error("local bus mode not routed");
  a_f1_pp_route: assert property (take && req_func_i && // RULE8
      f1_mode_i == pci_route_pkg::MODE_101 && req_bar_i == pci_route_pkg::BAR1 &&
      req_io_i |=> claim_o && target_o == pci_route_pkg::TGT_PP_EXT)
    else $error("parallel extended block misrouted");
  a_f1_disabled: assert property (take && req_func_i && // RULE12
      f1_mode_i == pci_route_pkg::MODE_010 |=> miss_o && !claim_o)
    else $error("disabled function claimed");
  a_idle_quiet: assert property (ce_i && !req_valid_i |=> !claim_o && !miss_o) // RULE11
    else $error("answer without request");

  c_bar5_lcr: cover property (claim_o && target_o == pci_route_pkg::TGT_LCR && unique_bar);
  c_unique_ch3: cover property (claim_o && channel_o == 2'h3 && unique_bar);
  c_pp_base: cover property (claim_o && target_o == pci_route_pkg::TGT_PP_BASE);
  c_miss: cover property (miss_o);

endmodule

`default_nettype wire

// ==== pci_host_model.sv ====
/*
  behavioural pci host bridge that presents target accesses to the decoder.
  assumes the bench calls its tasks at the rising edge of clock_i.
*/
`default_nettype none

module pci_host_model (
  input  wire logic        clock_i,
  output logic             req_valid_o,
  output logic             req_func_o,
  output logic [2:0]       req_bar_o,
  output logic             req_io_o,
  output logic [11:0]      req_offset_o,
  output logic [2:0]       f0_mode_o,
  output logic             f0_unique_opt_o,
  output logic [2:0]       f1_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle state
  initial begin
    req_valid_o     = 1'b0;
    req_func_o      = 1'b0;
    req_bar_o       = 3'h0;
    req_io_o        = 1'b0;
    req_offset_o    = 12'h000;
    f0_mode_o       = 3'h0;
    f0_unique_opt_o = 1'b0;
    f1_mode_o       = 3'h0;
  end

  // ==========================================================
  // window sizing
  // i/o offsets stay inside the block size given to each i/o bar; memory offsets pass unchanged
  function automatic logic [11:0] fit(input logic f, input logic [2:0] b, input logic io,
                                      input logic [11:0] o, input logic [2:0] m0,
                                      input logic u);
    logic per;
    per = (m0 == 3'h3) || ((m0 == 3'h4 || m0 == 3'h5) && u);
    if (io && !f && per && b < 3'h4) return o & 12'h007;
    return io ? (o & 12'h01f) : o;
  endfunction

  // ==========================================================
  // request tasks
  task automatic set_modes(input logic [2:0] m0, input logic u, input logic [2:0] m1);
    f0_mode_o       <= m0;
    f0_unique_opt_o <= u;
    f1_mode_o       <= m1;
  endtask

  // released bar, i/o and offset lines show the inverse of their last value; the function line holds
  task automatic drive(input logic v, input logic f, input logic [2:0] b, input logic io,
                       input logic [11:0] o);
    req_valid_o <= v;
    if (v) begin
      req_func_o   <= f;
      req_bar_o    <= b;
      req_io_o     <= io;
      req_offset_o <= o;
    end else begin
      req_bar_o    <= ~req_bar_o;
      req_io_o     <= ~req_io_o;
      req_offset_o <= ~req_offset_o;
    end
  endtask
endmodule

`default_nettype wire

// ==== tb_pci_bar_resource_decoder.sv ====
/*
  self-checking bench for the bar resource decoder, random and directed accesses.
  assumes pci_route_pkg, route_if, f1_route_decode and the host model are compiled first.
*/
`default_nettype none

module tb_pci_bar_resource_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic                          clock_i;
  logic                          reset_i;
  logic                          ce_i;
  logic                          v;
  logic                          fn;
  logic [2:0]                    bar;
  logic                          io;
  logic [11:0]                   ofs;
  logic [2:0]                    m0;
  logic                          uo;
  logic [2:0]                    m1;
  logic                          claim_o;
  logic                          miss_o;
  pci_route_pkg::target_e        target_o;
  logic [1:0]                    channel_o;
  logic [7:0]                    res_offset_o;
  logic [14:0]                   seen;
  logic [14:0]                   prev_exp;
  logic [14:0]                   prev_mask;
  logic [2:0]                    nm0;
  logic                          nu;
  logic [2:0]                    nm1;
  logic [31:0]                   r;
  int                            err_total;
  int                            comparisons;
  int                            seed;

  assign seen = {claim_o, miss_o, target_o, channel_o, res_offset_o};

  // ==========================================================
  // instances
  pci_host_model host (.clock_i(clock_i), .req_valid_o(v), .req_func_o(fn), .req_bar_o(bar),
    .req_io_o(io), .req_offset_o(ofs), .f0_mode_o(m0), .f0_unique_opt_o(uo), .f1_mode_o(m1));

  pci_bar_resource_decoder dut (.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i),
    .req_valid_i(v), .req_func_i(fn), .req_bar_i(bar), .req_io_i(io), .req_offset_i(ofs),
    .f0_mode_i(m0), .f0_unique_opt_i(uo), .f1_mode_i(m1), .claim_o(claim_o),
    .miss_o(miss_o), .target_o(target_o), .channel_o(channel_o),
    .res_offset_o(res_offset_o));

  // ==========================================================
  // expected decode: {claim, miss, target, channel, offset}
  function automatic logic [14:0] exp_f(input logic f, input logic [2:0] b, input logic i,
                                        input logic [11:0] o, input logic [2:0] a0,
                                        input logic u, input logic [2:0] a1);
    logic       per;
    logic       lb;
    logic       pp;
    logic [2:0] t;
    logic [1:0] c;
    logic [7:0] s;
    per = (a0 == 3'h3) || ((a0 == 3'h4 || a0 == 3'h5) && u);
    lb  = (a1 == 3'h0) || (a1 == 3'h3) || (a1 == 3'h4);
    pp  = (a1 == 3'h1) || (a1 == 3'h5);
    t = pci_route_pkg::TGT_NONE;
    c = 2'h0;
    s = o[7:0];
    if (!f) begin
      if (per && i && b < 3'h4) begin
        t = pci_route_pkg::TGT_UART;
        c = b[1:0];
        s = {5'h00, o[2:0]};
      end else if (per && i && b == 3'h4) t = pci_route_pkg::TGT_LCR;
      else if (per && !i && b == 3'h5 && o[7]) t = pci_route_pkg::TGT_LCR;
      else if ((per && !i && b == 3'h5) || (!per && !i && b == 3'h1)) begin
        t = pci_route_pkg::TGT_UART;
        c = o[6:5];
        s = {5'h00, o[4:2]};
      end else if (!per && i && b == 3'h0) begin
        t = pci_route_pkg::TGT_UART;
        c = o[4:3];
        s = {5'h00, o[2:0]};
      end else if (!per && ((i && b == 3'h2) || (!i && b == 3'h3))) t = pci_route_pkg::TGT_LCR;
    end else if (f && (lb || pp)) begin
      if ((i && b == 3'h2) || (!i && b == 3'h3)) t = pci_route_pkg::TGT_LCR;
      else if (lb && ((i && b == 3'h0) || (!i && b == 3'h1))) t = pci_route_pkg::TGT_LBUS;
      else if (pp && i && b == 3'h0) t = pci_route_pkg::TGT_PP_BASE;
      else if (pp && i && b == 3'h1) t = pci_route_pkg::TGT_PP_EXT;
    end
    return {t != 3'h0, t == 3'h0, t, c, s};
  endfunction

  // ==========================================================
  // compare and finish
  task automatic check(input logic [14:0] got, input logic [14:0] want);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("BAD %0t decode seen %h expected %h", $time, got, want);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // drive one cycle, then check the request taken at this edge
  task automatic step(input logic sv, input logic f, input logic [2:0] b, input logic i,
                      input logic [11:0] o);
    logic [11:0] fo;
    logic [14:0] e;
    fo = host.fit(f, b, i, o, nm0, nu);
    @(posedge clock_i);
    host.set_modes(nm0, nu, nm1);
    host.drive(sv, f, b, i, fo);
    #1;
    check(seen & prev_mask, prev_exp & prev_mask);
    e = exp_f(f, b, i, fo, nm0, nu, nm1);
    prev_exp  = sv ? e : 15'h0000;
    prev_mask = !sv ? 15'h6000 : (e[13] ? 15'h7c00 : 15'h7fff);
  endtask

  // ==========================================================
  // clock, watchdog and sequence
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  initial begin
    seed = 41;
    reset_i = 1'b1;
    ce_i = 1'b1;
    err_total = 0;
    comparisons = 0;
    prev_exp = 15'h0000;
    prev_mask = 15'h0000;
    nm0 = 3'h0;
    nu = 1'b0;
    nm1 = 3'h0;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    #1 check(seen, 15'h0000);
    step(1'b1, 1'b0, 3'h0, 1'b1, 12'h01a);
    step(1'b1, 1'b0, 3'h1, 1'b0, 12'hf64);
    step(1'b1, 1'b0, 3'h4, 1'b1, 12'h000);
    step(1'b1, 1'b0, 3'h0, 1'b1, 12'h008);
    // freeze with the clock enable low; a request meanwhile is not taken
    @(posedge clock_i);
    ce_i <= 1'b0;
    host.drive(1'b1, 1'b1, 3'h0, 1'b1, 12'h001);
    #1 check(seen & prev_mask, prev_exp & prev_mask);
    @(posedge clock_i);
    ce_i <= 1'b1;
    host.drive(1'b0, 1'b0, 3'h0, 1'b0, 12'h000);
    #1 check(seen & prev_mask, prev_exp & prev_mask);
    prev_exp = 15'h0000;
    prev_mask = 15'h6000;
    for (int m = 0; m < 16; m++) begin
      nm0 = m[2:0];
      nu = m[3];
      nm1 = 3'(m * 3);
      step(1'b0, 1'b0, 3'h0, 1'b0, 12'h000);
      step(1'b1, 1'b0, 3'h5, 1'b0, 12'h07c);
      step(1'b1, 1'b0, 3'h5, 1'b0, 12'h080);
      step(1'b1, 1'b1, 3'h1, 1'b0, 12'h033);
      step(1'b1, 1'b1, 3'h1, 1'b1, 12'h004);
      step(1'b1, 1'b1, 3'h0, 1'b1, 12'h0c1);
      repeat (40) begin
        r = $random(seed);
        step(r[0] | r[1], r[2], r[5:3], r[6], r[18:7]);
      end
    end
    // reset in mid-run clears the outputs
    @(posedge clock_i);
    reset_i <= 1'b1;
    host.drive(1'b1, 1'b0, 3'h0, 1'b1, 12'h01f);
    #1 check(seen & prev_mask, prev_exp & prev_mask);
    @(posedge clock_i);
    reset_i <= 1'b0;
    host.drive(1'b0, 1'b0, 3'h0, 1'b0, 12'h000);
    #1 check(seen, 15'h0000);
    // first request after the second release
    prev_exp = 15'h0000;
    prev_mask = 15'h6000;
    step(1'b1, 1'b0, 3'h0, 1'b1, 12'h01a);
    step(1'b0, 1'b0, 3'h0, 1'b0, 12'h000);
    wrap_up();
  end
endmodule

`default_nettype wire
